// ### tb_tpf.sv
// Purpose: self-checking bench for tpf_framer
// Assumes: index wraps after 2, protocol select 1
// Notes: notes queued by drivers, popped by the monitor
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 0, rst_b = 0, req_valid = 0, req_wlast = 0, rsp_ready = 0;
  logic [7:0] req_func = 0, req_qty = 0, can_byte;
  logic [15:0] req_addr = 0, req_wdata = 0, v, w;
  wire [15:0] par_value, rsp_word, cfg_out_word;
  wire [5:0] par_num;
  wire [7:0] rsp_exc_code, cfg_out_idx;
  wire can_byte_valid, can_byte_ready, req_ready, rsp_valid, rsp_last;
  wire rsp_exc, cfg_out_we;
  logic [7:0] qc[$];
  logic [26:0] qr[$], n; // [26] word checked, exc, last, code, word
  logic [23:0] qw[$];
  integer seed = 66, mismatches = 0, comparisons = 0, cyc = 0, i, s;
  always #5 clk = ~clk;
  tpf_framer u_dut (.clk(clk), .rst_b(rst_b), .can_proto_sel(2'h1),
    .can_last_index(8'h02), .can_byte(can_byte),
    .can_byte_valid(can_byte_valid), .can_byte_ready(can_byte_ready),
    .can_frame_start(), .par_num(par_num), .par_value(par_value),
    .req_valid(req_valid), .req_ready(req_ready), .req_func(req_func),
    .req_addr(req_addr), .req_qty(req_qty), .req_wdata(req_wdata),
    .req_wlast(req_wlast), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_word(rsp_word), .rsp_last(rsp_last), .rsp_exc(rsp_exc),
    .rsp_exc_code(rsp_exc_code), .cfg_out_word(cfg_out_word),
    .cfg_out_idx(cfg_out_idx), .cfg_out_we(cfg_out_we));
  tpf_partner u_far (.clk(clk), .par_num(par_num), .par_value(par_value),
    .can_byte_ready(can_byte_ready));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, e, g);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // one request beat held until taken, optional wait for its answers
  task rq(input [7:0] f, input [15:0] a, input [7:0] q, input [15:0] d,
    input l, input wt);
    req_valid <= 1; req_func <= f; req_addr <= a;
    req_qty <= q; req_wdata <= d; req_wlast <= l;
    @(negedge clk);
    while (!req_ready) @(negedge clk);
    @(posedge clk);
    req_valid <= 0;
    if (!wt) @(posedge clk); // let an edge pass before the next beat
    while (wt && qr.size()) @(posedge clk);
  endtask
  task dw(input [15:0] x, input c); qr.push_back({c, 10'h0, x}); endtask
  task ex(input [7:0] c); qr.push_back({3'b011, c, 16'h0}); endtask
  ////////////////////////////////////////////////////////////////////////
  // watcher: every seen answer and cfg write against its oldest note, can bytes only while notes remain
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin mismatches++; complete_run; end
    rsp_ready <= $random(seed); // answer side stalls too
    if (rst_b && can_byte_valid && can_byte_ready && qc.size())
      chk("can_byte", qc.pop_front(), can_byte);
    if (rst_b && rsp_valid && rsp_ready) begin
      n = qr.size() ? qr.pop_front() : 27'h7FFFFFF;
      chk("rsp", n[25:0], {rsp_exc, rsp_last, rsp_exc_code,
        n[26] ? rsp_word : n[15:0]});
    end
    if (rst_b && cfg_out_we)
      chk("cfg", qw.pop_front(), {cfg_out_idx, cfg_out_word});
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (i = 0; i < 6; i++) begin // two rounds of indices 0..2
      qc.push_back(i % 3);
      for (s = 1; s < 4; s++) begin
        v = (i % 3 == 0 && s == 1) ? 16'h14B6
          : {4'hC, {2{6'(i % 3 * 3 + s - 1)}}};
        qc.push_back(v[7:0]);
        qc.push_back(v[15:8]);
      end
      qc.push_back(8'h00);
    end
    repeat (6) @(posedge clk);
    rst_b <= 1;
    dw(16'h14B4, 1); qr[$][24] = 1; // one word, flagged last
    rq(8'h03, 16'hC350, 1, 0, 0, 1);
    v = $random(seed); w = $random(seed);
    qw.push_back({8'h05, v}); dw(0, 0); qr[$][24] = 1;
    rq(8'h06, 16'h0005, 1, v, 0, 1);
    qw.push_back({8'h07, v}); qw.push_back({8'h08, w});
    dw(0, 0); qr[$][24] = 1;
    rq(8'h10, 16'h0007, 2, v, 0, 0);
    rq(8'h10, 16'h0008, 2, w, 1, 1);
    dw(v, 1); dw(w, 1); qr[$][24] = 1; // last data word flagged
    rq(8'h03, 16'h0007, 2, 0, 0, 1);
    ex(1); rq(8'h04, 0, 1, 0, 0, 1);
    ex(2); rq(8'h03, 16'h0300, 1, 0, 0, 1);
    ex(3); rq(8'h03, 0, 0, 0, 0, 1);
    ex(3); rq(8'h03, 0, 129, 0, 0, 1);
    dw(16'h14B4, 1);
    for (i = 0; i < 126; i++) dw(0, 0);
    dw(0, 0); qr[$][24] = 1;
    rq(8'h03, 16'hC350, 128, 0, 0, 1);
    while (qc.size()) @(posedge clk);
    complete_run;
  end
endmodule
`default_nettype wire

// ### tpf_defs.vh
// Purpose: constants for the telemetry protocol framer
// Assumes: 100 MHz clock, one clock domain
// Notes: definitions only
`ifndef TPF_DEFS_VH
`define TPF_DEFS_VH
`define TPF_FRAME_BYTES 4'h8
`define TPF_MUX_LAST_DEF 8'h1F
`define TPF_FIFO_DEPTH 4
`define TPF_FIFO_AW 2
`define TPF_PROTO_SERIAL 16'h14B4
`define TPF_PROTO_CAN_A 16'h14B5
`define TPF_PROTO_CAN_B 16'h14B6
`define TPF_PROTO_UNIT 16'h1773
`define TPF_FC_READ_HOLD 8'h03
`define TPF_FC_WRITE_ONE 8'h06
`define TPF_FC_WRITE_MANY 8'h10
`define TPF_VIS_BASE 16'hC350
`define TPF_VIS_SIZE 16'h0100
`define TPF_CFG_BASE 16'h0000
`define TPF_CFG_SIZE 16'h0100
`define TPF_MAX_READ 8'h80
`define TPF_EXC_FUNC 8'h01
`define TPF_EXC_ADDR 8'h02
`define TPF_EXC_VALUE 8'h03
`define TPF_PAR_AW 6
`endif

// ### tpf_fifo.v
// Purpose: small valid/ready FIFO for frame bytes
// Assumes: single clock, synchronous inputs
// Notes: full and empty are exact; write blocked when full
`timescale 1ns/1ns
`default_nettype none
module tpf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
  reg [AW-1:0] wr_ptr_r; // write pointer
  reg [AW-1:0] rd_ptr_r; // read pointer
  reg [AW:0] count_r; // fill level
  wire push;
  wire pop;
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  //////////////////////////////////////////////////////////////////////
  // storage write, no reset needed on data
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
  // pointers and level
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tpf_framer.v
// Purpose: multiplexed CAN data frames plus Modbus register slave core
// Assumes: byte streams already framed/CRC-checked outside; one clock
// Notes: CAN bytes leave through a 4-word FIFO; requests come as fields
`timescale 1ns/1ns
`default_nettype none
`include "tpf_defs.vh"
module tpf_framer (
  input wire clk,
  input wire rst_b,
  // can frame stream out
  input wire [1:0] can_proto_sel,
  input wire [7:0] can_last_index,
  output wire [7:0] can_byte,
  output wire can_byte_valid,
  input wire can_byte_ready,
  output reg can_frame_start,
  // parameter source: 16-bit values by number
  output reg [`TPF_PAR_AW-1:0] par_num,
  input wire [15:0] par_value,
  // modbus request fields from outer serial layer
  input wire req_valid,
  output wire req_ready,
  input wire [7:0] req_func,
  input wire [15:0] req_addr,
  input wire [7:0] req_qty,
  input wire [15:0] req_wdata,
  input wire req_wlast,
  // answer words
  output reg rsp_valid,
  input wire rsp_ready,
  output reg [15:0] rsp_word,
  output reg rsp_last,
  output reg rsp_exc,
  output reg [7:0] rsp_exc_code,
  // configuration register values for the rest of the unit
  output reg [15:0] cfg_out_word,
  output reg [7:0] cfg_out_idx,
  output reg cfg_out_we
);
  //////////////////////////////////////////////////////////////////////
  // helpers
  // low or high octet of a little-endian word
  function [7:0] le_byte;
    input [15:0] w;
    input hi;
    begin
      // bits copied untouched, so unsigned and two's complement both pass
      le_byte = hi ? w[15:8] : w[7:0];
    end
  endfunction
  // protocol identity for selected CAN set
  function [15:0] can_proto_id;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: can_proto_id = `TPF_PROTO_CAN_A;
        2'h1: can_proto_id = `TPF_PROTO_CAN_B;
        default: can_proto_id = `TPF_PROTO_UNIT;
      endcase
    end
  endfunction
  //////////////////////////////////////////////////////////////////////
  // CAN frame builder
  reg [7:0] frame_index_byte_r; // current multiplex index
  reg [3:0] pos_r; // byte position 0..7
  reg [15:0] word_r; // latched parameter value
  reg [7:0] tx_byte; // byte offered to fifo
  wire fifo_in_ready;
  wire [7:0] last_idx;
  // zero limit means use default table length
  assign last_idx = (can_last_index == 8'h00) ? `TPF_MUX_LAST_DEF
                                               : can_last_index;
  // parameter number: index times three plus slot, fixed table
  always @* begin
    // word slot k (0..2) sits in bytes 2k+1 and 2k+2
    par_num = frame_index_byte_r[`TPF_PAR_AW-1:0] * 6'h03
              + {3'h0, pos_r[3:1]};
    if (pos_r == 4'h0) begin
      par_num = {`TPF_PAR_AW{1'b0}};
    end
  end
  // byte mux per position
  always @* begin
    case (pos_r)
      4'h0: tx_byte = frame_index_byte_r;
      4'h7: tx_byte = 8'h00; // internal byte, content free
      default: begin
        // index 0 carries the protocol id in its first word
        if (frame_index_byte_r == 8'h00 && (pos_r == 4'h1 || pos_r == 4'h2)) begin
          tx_byte = le_byte(can_proto_id(can_proto_sel), ~pos_r[0]);
        end else if (pos_r[0]) begin
          tx_byte = le_byte(par_value, 1'b0); // low first
        end else begin
          tx_byte = le_byte(word_r, 1'b1); // then high
        end
      end
    endcase
  end
  // advance position and index as fifo accepts
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_index_byte_r <= 8'h00;
      pos_r <= 4'h0;
      word_r <= 16'h0000;
      can_frame_start <= 1'b0;
    end else begin
      can_frame_start <= 1'b0;
      if (fifo_in_ready) begin
        if (pos_r[0]) begin
          word_r <= par_value; // hold high half for next byte
        end
        if (pos_r == 4'h0) begin
          can_frame_start <= 1'b1;
        end
        if (pos_r == `TPF_FRAME_BYTES - 4'h1) begin
          pos_r <= 4'h0;
          if (frame_index_byte_r >= last_idx) begin
            frame_index_byte_r <= 8'h00; // wrap to first
          end else begin
            frame_index_byte_r <= frame_index_byte_r + 8'h01;
          end
        end else begin
          pos_r <= pos_r + 4'h1;
        end
      end
    end
  end
  // frame bytes buffered, sink may stall
  tpf_fifo #(
    .WIDTH(8),
    .DEPTH(`TPF_FIFO_DEPTH),
    .AW(`TPF_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(tx_byte),
    .in_valid(1'b1),
    .in_ready(fifo_in_ready),
    .out_data(can_byte),
    .out_valid(can_byte_valid),
    .out_ready(can_byte_ready)
  );
  //////////////////////////////////////////////////////////////////////
  // modbus slave: only answers requests
  localparam S_IDLE = 3'b001;
  localparam S_READ = 3'b010;
  localparam S_ANS = 3'b100;
  reg [2:0] state_r;
  reg [15:0] cfg_mem [0:255]; // config and remote-control words
  reg [15:0] vis_mem [0:255]; // visualization words
  reg [15:0] addr_r; // running read address
  reg [7:0] left_r; // words still to send
  reg in_vis_r; // read targets visualization
  wire is_vis; // address in visualization range
  wire is_cfg; // address in config range
  wire [16:0] req_end; // one past last addressed word
  assign req_end = {1'b0, req_addr} + {9'h000, req_qty};
  // ranges kept apart bus address 50000 is 450001
  assign is_vis = req_addr >= `TPF_VIS_BASE &&
                  req_end <= {1'b0, `TPF_VIS_BASE} + {1'b0, `TPF_VIS_SIZE};
  assign is_cfg = req_end <= {1'b0, `TPF_CFG_BASE} + {1'b0, `TPF_CFG_SIZE};
  assign req_ready = (state_r == S_IDLE);
  // visualization word 0 holds the serial protocol id
  always @(posedge clk) begin
    vis_mem[0] <= `TPF_PROTO_SERIAL;
  end
  // request handling
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      addr_r <= 16'h0000;
      left_r <= 8'h00;
      in_vis_r <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_word <= 16'h0000;
      rsp_last <= 1'b0;
      rsp_exc <= 1'b0;
      rsp_exc_code <= 8'h00;
      cfg_out_word <= 16'h0000;
      cfg_out_idx <= 8'h00;
      cfg_out_we <= 1'b0;
    end else begin
      cfg_out_we <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (req_valid) begin
            rsp_exc <= 1'b0;
            // stale code from an earlier refusal must not leak forward
            rsp_exc_code <= 8'h00;
            if (req_func == `TPF_FC_READ_HOLD) begin
              // 1..128 words per read
              if (req_qty == 8'h00 || req_qty > `TPF_MAX_READ) begin
                rsp_exc <= 1'b1;
                rsp_exc_code <= `TPF_EXC_VALUE;
                state_r <= S_ANS;
              end else if (is_vis || is_cfg) begin
                addr_r <= req_addr;
                left_r <= req_qty;
                in_vis_r <= is_vis;
                state_r <= S_READ;
              end else begin
                rsp_exc <= 1'b1;
                rsp_exc_code <= `TPF_EXC_ADDR;
                state_r <= S_ANS;
              end
            end else if (req_func == `TPF_FC_WRITE_ONE ||
                         req_func == `TPF_FC_WRITE_MANY) begin
              // writes reach config range only
              if (req_addr < `TPF_CFG_SIZE) begin
                cfg_mem[req_addr[7:0]] <= req_wdata;
                cfg_out_word <= req_wdata;
                cfg_out_idx <= req_addr[7:0];
                cfg_out_we <= 1'b1;
                if (req_wlast || req_func == `TPF_FC_WRITE_ONE) begin
                  rsp_word <= req_wdata;
                  state_r <= S_ANS;
                end
              end else begin
                rsp_exc <= 1'b1;
                rsp_exc_code <= `TPF_EXC_ADDR;
                state_r <= S_ANS;
              end
            end else begin
              rsp_exc <= 1'b1;
              rsp_exc_code <= `TPF_EXC_FUNC;
              state_r <= S_ANS;
            end
          end
        end
        S_READ: begin
          // stream one word per accepted beat
          if (!rsp_valid || rsp_ready) begin
            rsp_valid <= 1'b1;
            rsp_word <= in_vis_r ? vis_mem[addr_r[7:0] - 8'h50]
                                 : cfg_mem[addr_r[7:0]];
            rsp_last <= (left_r == 8'h01);
            addr_r <= addr_r + 16'h0001;
            left_r <= left_r - 8'h01;
            if (left_r == 8'h01) begin
              state_r <= S_ANS;
            end
          end
        end
        S_ANS: begin
          // single closing beat for writes and errors
          if (rsp_valid && rsp_last) begin
            if (rsp_ready) begin
              rsp_valid <= 1'b0;
              rsp_last <= 1'b0;
              state_r <= S_IDLE;
            end
          end else if (!rsp_valid) begin
            rsp_valid <= 1'b1;
            rsp_last <= 1'b1;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tpf_partner.sv
// Purpose: far side model, parameter source and stalling frame sink
// Assumes: parameter values are a fixed function of their number
// Notes: ready stalls at random to exercise the fifo
`timescale 1ns/1ns
`default_nettype none
module tpf_partner (
  input wire clk,
  input wire [5:0] par_num,
  output logic [15:0] par_value,
  output logic can_byte_ready
);
  integer pseed = 66; // own seed, fixed
  // value by number, distinct bytes so order errors show
  assign par_value = {4'hC, par_num, par_num};
  initial can_byte_ready = 1'b0;
  // sink takes or stalls; content of byte 8 is not used here
  always @(posedge clk) can_byte_ready <= $random(pseed);
endmodule
`default_nettype wire

// ### tpf_properties.sv
// Purpose: port checker for tpf_framer
// Assumes: one clock, rst_b async active low
// Notes: bound to every tpf_framer instance
`timescale 1ns/1ns
`default_nettype none
module tpf_props (
  input wire clk,
  input wire rst_b,
  input wire [7:0] can_byte,
  input wire can_byte_valid,
  input wire can_byte_ready,
  input wire can_frame_start,
  input wire req_valid,
  input wire req_ready,
  input wire [7:0] req_func,
  input wire [7:0] req_qty,
  input wire req_wlast,
  input wire rsp_valid,
  input wire rsp_ready,
  input wire [15:0] rsp_word,
  input wire rsp_last,
  input wire rsp_exc,
  input wire [7:0] rsp_exc_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire take = req_valid && req_ready;
  reg pend_r; // a request is open, so an answer may appear
  // open on take, close on the final answer beat
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) pend_r <= 1'b0;
    else if (take) pend_r <= 1'b1;
    else if (rsp_valid && rsp_ready && rsp_last) pend_r <= 1'b0;
  end
  property p_unsol; rsp_valid |-> pend_r; endproperty
  a_unsol: assert property (p_unsol) else $error("answer unasked");
  property p_busy; take && req_func == 8'h03 |=> !req_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_soon;
    take && (req_func != 8'h10 || req_wlast) |-> ##[1:2] rsp_valid;
  endproperty
  a_soon: assert property (p_soon) else $error("answer late");
  property p_rhold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_word)
      && $stable(rsp_last);
  endproperty
  a_rhold: assert property (p_rhold) else $error("answer dropped");
  property p_chold;
    can_byte_valid && !can_byte_ready |=> can_byte_valid && $stable(can_byte);
  endproperty
  a_chold: assert property (p_chold) else $error("byte dropped");
  property p_fgap; can_frame_start |=> !can_frame_start [*7]; endproperty
  a_fgap: assert property (p_fgap) else $error("frame short");
  property p_efunc;
    take && !(req_func inside {8'h03, 8'h06, 8'h10}) |-> ##[1:2]
      rsp_valid && rsp_exc && rsp_exc_code == 8'h01 && rsp_last;
  endproperty
  a_efunc: assert property (p_efunc) else $error("bad code 1");
  property p_eqty;
    take && req_func == 8'h03 && (req_qty == 8'h00 || req_qty > 8'h80)
      |-> ##[1:2] rsp_valid && rsp_exc && rsp_exc_code == 8'h03;
  endproperty
  a_eqty: assert property (p_eqty) else $error("bad code 3");
  c_read: cover property (take && req_func == 8'h03);
  c_wr: cover property (take && req_func == 8'h10 && req_wlast);
  c_stall: cover property (can_byte_valid && !can_byte_ready);
endmodule
bind tpf_framer tpf_props u_props (.clk, .rst_b, .can_byte, .can_byte_valid,
  .can_byte_ready, .can_frame_start, .req_valid, .req_ready, .req_func,
  .req_qty, .req_wlast, .rsp_valid, .rsp_ready, .rsp_word, .rsp_last,
  .rsp_exc, .rsp_exc_code);
`default_nettype wire
